/* File: verilog/flash_pwr_cfg.svh */
// Timing counts and command codes for the flash power and reset controller
`ifndef FLASH_PWR_CFG_SVH
`define FLASH_PWR_CFG_SVH
`define CLK_PERIOD_PS        32'h0000_1F40
`define RECOVERY_TIME_PS     32'h0004_93E0
`define RECOVERY_CYCLES      ((`RECOVERY_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_ARRAY_CMD       16'h00FF
`define STROBE_CYCLES        8'h04
`define RESET_HOLD_CYCLES    8'h10
`endif

/* File: verilog/flash_pwr_pkg.sv */
// Types shared by the flash power and reset controller
package flash_pwr_pkg;
    typedef enum logic [2:0] {
        ST_RESET,
        ST_RECOVER,
        ST_READY,
        ST_READ,
        ST_WRITE,
        ST_GAP
    } phase_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [17:0] addr;
        logic [15:0] data;
    } host_req_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        powerdown_reset_n;
        logic [17:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe;
    } flash_pins_t;
endpackage

/* File: verilog/flash_power_reset_control.sv */
// Host-side controller driving flash chip-select, strobes and reset pin
`timescale 1ns/1ps
`include "flash_pwr_cfg.svh"
// Operation
// RULE1 - Chip-select low with reset pin high puts device active.
// RULE2 - Device idles in low power after reads, keeping read data driven.
// RULE3 - Chip-select high in read state floats device data outputs.
// RULE4 - Program or erase continues when chip-select is released.
// RULE5 - Reset pin low puts device into deep power-down.
// RULE6 - Reset pin low during reads floats device outputs.
// RULE7 - Host waits the recovery time after reset release before reading.
// RULE8 - Reset pin low aborts program or erase, corrupting contents.
// RULE9 - Reset pin low or power loss clears the status register.
// RULE10 - Command interface powers up in read mode.
// RULE11 - After power-up host drops chip-select or presents new address.
// RULE12 - Writes need write-enable and chip-select both low.
// RULE13 - Device alters memory only after a two-step command.
// RULE14 - Device ignores control inputs while reset pin is low.
// RULE15 - Latched commands survive supply, chip-select and internal activity.
// RULE16 - Command interface returns to read array after deep power-down.
// RULE17 - Host issues read-array before reading after program or erase.
// RULE18 - Reset pin follows the system reset, like the CPU.
// RULE19 - Read-array command is the value FF hex.
// RULE20 - Device outputs stay floating during recovery.
module flash_power_reset_control
#(
    parameter int unsigned RECOVERY_CYCLES = `RECOVERY_CYCLES
)
(
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic                      sys_reset_n,
    input  wire logic                      powerdown_req,
    input  wire logic                      array_restore,
    input  wire flash_pwr_pkg::host_req_t  req,
    output logic                           req_ready,
    output logic                           rsp_valid,
    output logic [15:0]                    rsp_data,
    output logic                           array_mode,
    output flash_pwr_pkg::flash_pins_t     pins,
    input  wire logic [15:0]               dq_in
);
    import flash_pwr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        phase_t      phase;
        logic [15:0] wait_cnt;
        logic        array_mode;
        logic        req_ready;
        logic        rsp_valid;
        logic [15:0] rsp_data;
        flash_pins_t pins;
        logic        sys_sync1;
        logic        sys_sync2;
        logic        pd_sync1;
        logic        pd_sync2;
        logic [15:0] dq_sync1;
        logic [15:0] dq_sync2;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic   hold_reset;
    assign  hold_reset = !cur.sys_sync2 || cur.pd_sync2;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;
        next_cur.sys_sync1 = sys_reset_n;
        next_cur.sys_sync2 = cur.sys_sync1;
        next_cur.pd_sync1  = powerdown_req;
        next_cur.pd_sync2  = cur.pd_sync1;
        // The data bus is a pin, so it crosses two stages like the others
        next_cur.dq_sync1  = dq_in;
        next_cur.dq_sync2  = cur.dq_sync1;
        next_cur.rsp_valid = 1'b0;
        next_cur.req_ready = 1'b0;
        // Software-side mark that read array needs restoring after program or erase; clears array_mode
        if (array_restore)
        begin
            next_cur.array_mode = 1'b0;
        end
        if (hold_reset)
        begin
            // Either reset source parks the pin low and drops any access
            // Aborting any program or erase is accepted by design here
            next_cur.phase = ST_RESET;                           // RULE18
            next_cur.pins.powerdown_reset_n = 1'b0;              // RULE5
            next_cur.pins.ce_n  = 1'b1;
            next_cur.pins.oe_n  = 1'b1;
            next_cur.pins.we_n  = 1'b1;
            next_cur.pins.dq_oe = 1'b0;
            next_cur.wait_cnt   = 16'h0000;
            next_cur.array_mode = 1'b1;                          // RULE16
        end
        else
        begin
            case (cur.phase)
                ST_RESET:
                begin
                    next_cur.pins.powerdown_reset_n = 1'b1;
                    next_cur.wait_cnt = 16'h0000;
                    next_cur.phase    = ST_RECOVER;
                end
                ST_RECOVER:
                begin
                    // Outputs of the device are not valid yet; no read issued
                    next_cur.wait_cnt = cur.wait_cnt + 16'h0001;
                    if (cur.wait_cnt >= 16'(RECOVERY_CYCLES - 1))      // RULE7
                    begin
                        next_cur.phase     = ST_READY;
                        next_cur.req_ready = 1'b1;
                    end
                end
                ST_READY:
                begin
                    next_cur.req_ready = 1'b1;
                    if (req.req && cur.req_ready)
                    begin
                        next_cur.req_ready = 1'b0;
                        next_cur.wait_cnt  = 16'h0000;
                        next_cur.pins.addr = req.addr;           // RULE11
                        next_cur.pins.ce_n = 1'b0;               // RULE1
                        if (req.write)
                        begin
                            // Command write: write-enable and chip-select low together
                            next_cur.pins.we_n   = 1'b0;         // RULE12
                            next_cur.pins.dq_out = req.data;
                            next_cur.pins.dq_oe  = 1'b1;
                            next_cur.phase       = ST_WRITE;
                            if (req.data == `READ_ARRAY_CMD)     // RULE19
                            begin
                                next_cur.array_mode = 1'b1;      // RULE17
                            end
                        end
                        else
                        begin
                            next_cur.pins.oe_n = 1'b0;
                            next_cur.phase     = ST_READ;
                        end
                    end
                end
                ST_READ:
                begin
                    // Strobe length must cover both data synchroniser stages
                    next_cur.wait_cnt = cur.wait_cnt + 16'h0001;
                    if (cur.wait_cnt == 16'(`STROBE_CYCLES) - 16'h0001)
                    begin
                        // Synchronised copy, still since the strobe began
                        next_cur.rsp_data  = cur.dq_sync2;
                        next_cur.rsp_valid = 1'b1;
                        next_cur.pins.oe_n = 1'b1;
                        next_cur.pins.ce_n = 1'b1;               // RULE3
                        next_cur.wait_cnt  = 16'h0000;
                        next_cur.phase     = ST_GAP;
                    end
                end
                ST_WRITE:
                begin
                    next_cur.wait_cnt = cur.wait_cnt + 16'h0001;
                    if (cur.wait_cnt == 16'(`STROBE_CYCLES) - 16'h0001)
                    begin
                        // Raising write-enable first keeps data held past edge
                        next_cur.pins.we_n = 1'b1;
                        next_cur.wait_cnt  = 16'h0000;
                        next_cur.phase     = ST_GAP;
                        next_cur.rsp_valid = 1'b1;
                    end
                end
                ST_GAP:
                begin
                    // Idle cycle between accesses; after a write, chip-select only goes high at its end
                    next_cur.pins.ce_n  = 1'b1;                  // RULE4
                    next_cur.pins.dq_oe = 1'b0;
                    next_cur.req_ready  = 1'b1;
                    next_cur.phase      = ST_READY;
                end
                default:
                begin
                    next_cur.phase = ST_RESET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur <= '{phase: ST_RESET, wait_cnt: 16'h0000,
                     array_mode: 1'b1, req_ready: 1'b0,
                     rsp_valid: 1'b0, rsp_data: 16'h0000,
                     pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                             powerdown_reset_n: 1'b0,
                             addr: 18'h0_0000, dq_out: 16'h0000,
                             dq_oe: 1'b0},
                     sys_sync1: 1'b0, sys_sync2: 1'b0,
                     pd_sync1: 1'b0, pd_sync2: 1'b0,
                     dq_sync1: 16'h0000, dq_sync2: 16'h0000};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign req_ready  = cur.req_ready;
    assign rsp_valid  = cur.rsp_valid;
    assign rsp_data   = cur.rsp_data;
    assign array_mode = cur.array_mode;
    assign pins       = cur.pins;
endmodule

/* File: test/flash_power_reset_control_properties.sv */
// Port checks for the flash power and reset controller
`timescale 1ns/1ps
`include "flash_pwr_cfg.svh"
module flash_power_reset_control_properties
    import flash_pwr_pkg::*;
(
    input wire logic clk, resetn, sys_reset_n, powerdown_req, array_restore,
    input wire flash_pwr_pkg::host_req_t   req,
    input wire logic req_ready, rsp_valid, array_mode,
    input wire logic [15:0] rsp_data, dq_in,
    input wire flash_pwr_pkg::flash_pins_t pins
);
    logic take;
    assign take = req.req && req_ready;
    localparam int unsigned RECOVERY_MIN = `RECOVERY_CYCLES;
    logic [15:0] up_cnt;
    // Cycles the reset pin has stood high, saturating
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            up_cnt <= 16'h0000;
        else if (!pins.powerdown_reset_n)
            up_cnt <= 16'h0000;
        else if (up_cnt != 16'hFFFF)
            up_cnt <= up_cnt + 16'h0001;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence rd_strobe;
        (!pins.ce_n && !pins.oe_n && pins.powerdown_reset_n) [*4]
        ##1 rsp_valid;
    endsequence
    sequence wr_strobe;
        (!pins.ce_n && !pins.we_n && pins.dq_oe) [*4] ##1 rsp_valid;
    endsequence
    a_read_cycle: assert property (take && !req.write |=> rd_strobe)
        else $error("read strobe wrong");
    a_write_cycle: assert property (take && req.write |=> wr_strobe)
        else $error("write strobe wrong");
    a_we_gated: assert property (!pins.we_n |-> !pins.ce_n)
        else $error("write strobe without select");
    a_rd_data: assert property (rsp_valid && !$past(pins.oe_n) |->
        rsp_data == $past(dq_in)) else $error("read data wrong");
    a_recover_wait: assert property ($rose(pins.powerdown_reset_n) |->
        !req_ready [*8]) else $error("ready before recovery");
    a_early_select: assert property (!pins.ce_n |->
        up_cnt >= 16'(RECOVERY_MIN)) else $error("select during recovery");
    a_pd_request: assert property ($rose(powerdown_req) |->
        ##[1:6] !pins.powerdown_reset_n) else $error("no power-down");
    a_sys_reset: assert property ($fell(sys_reset_n) |->
        ##[1:6] !pins.powerdown_reset_n) else $error("no reset pin");
    a_restore_mode: assert property (array_restore |=> !array_mode)
        else $error("array mode kept");
    a_read_array: assert property (take && req.write &&
        req.data == 16'h00FF |-> ##[1:7] array_mode) else $error("no mode");
endmodule
bind flash_power_reset_control flash_power_reset_control_properties chk_u (
    .clk(clk), .resetn(resetn), .sys_reset_n(sys_reset_n), .req(req),
    .powerdown_req(powerdown_req), .array_restore(array_restore),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .array_mode(array_mode),
    .rsp_data(rsp_data), .dq_in(dq_in), .pins(pins));

/* File: test/flash_model.sv */
// Behavioural flash device answering the controller's pins
`timescale 1ns/1ps
`include "flash_pwr_cfg.svh"
module flash_model
    import flash_pwr_pkg::*;
(
    input  wire flash_pwr_pkg::flash_pins_t pins,
    output logic [15:0]                     dq
);
    logic [15:0] mem [logic [17:0]];
    logic [15:0] status = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic        array_rd = 1'b1;
    logic        setup = 1'b0;
    logic        recovered = 1'b0;
    // Reads stay invalid until the wake-up interval has run out
    always @(pins.powerdown_reset_n)
    begin
        recovered = 1'b0;
        if (pins.powerdown_reset_n)
            #(`RECOVERY_TIME_PS * 1ps) recovered = pins.powerdown_reset_n;
    end
    // Released bus shows the inverse word, so a stale value never passes
    assign dq = (pins.powerdown_reset_n && recovered && !pins.ce_n &&
        !pins.oe_n) ? last : ~last;
    always @(pins or array_rd or status)
        if (pins.powerdown_reset_n && !pins.ce_n && !pins.oe_n)
            last = !array_rd ? status : mem.exists(pins.addr)
                ? mem[pins.addr] : pins.addr[15:0];
    always @(posedge pins.we_n or negedge pins.powerdown_reset_n)
        if (!pins.powerdown_reset_n)
        begin
            status = 16'h0000;
            array_rd = 1'b1;
            setup = 1'b0;
        end
        else if (!pins.ce_n)
        begin
            if (setup)
                mem[pins.addr] = pins.dq_out;
            setup = (pins.dq_out == 16'h0040);
            array_rd = (pins.dq_out == 16'h00FF);
            status = 16'h0080;
        end
endmodule

/* File: test/flash_power_reset_control_tb.sv */
// Self-checking bench for the flash power and reset controller
`timescale 1ns/1ps
module flash_power_reset_control_tb;
    import flash_pwr_pkg::*;
    logic        clk = 1'b0;
    logic        resetn, sys_reset_n, powerdown_req, array_restore;
    logic        req_ready, rsp_valid, array_mode;
    logic [15:0] rsp_data, dq_in, q, d;
    logic [17:0] a;
    logic [31:0] seed = 32'h656e_9ece;
    int          mismatches = 0;
    int          check_count = 0;
    logic [15:0] sm_mem [int];
    bit          sm_rd = 1'b1;
    bit          sm_setup = 1'b0;
    host_req_t   req;
    flash_pins_t pins;
    always #4 clk = ~clk;
    flash_power_reset_control dut_u (.clk(clk), .resetn(resetn),
        .sys_reset_n(sys_reset_n), .powerdown_req(powerdown_req),
        .array_restore(array_restore), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .array_mode(array_mode),
        .pins(pins), .dq_in(dq_in));
    flash_model flash_u (.pins(pins), .dq(dq_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Reference of the far side: array, status after a write, setup step
    function automatic logic [15:0] sm_read(input logic [17:0] x);
        if (!sm_rd)
            return 16'h0080;
        return sm_mem.exists(x) ? sm_mem[x] : x[15:0];
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Called on a falling edge; returns on one with the answer in q
    task automatic xfer(logic w, logic [17:0] x, logic [15:0] v);
        repeat (100)
            if (req_ready !== 1'b1)
                @(negedge clk);
        req = '{1'b1, w, x, v};
        @(negedge clk);
        req.req = 1'b0;
        repeat (8)
            if (rsp_valid !== 1'b1)
                @(negedge clk);
        check("rsp_valid", 16'(rsp_valid), 16'h0001);
        q = rsp_data;
        if (w)
        begin
            if (sm_setup)
                sm_mem[x] = v;
            sm_setup = (v == 16'h0040);
            sm_rd = (v == 16'h00FF);
        end
        else
            check("model", q, sm_read(x));
        @(negedge clk);
    endtask
    initial
    begin
        resetn = 1'b0;
        sys_reset_n = 1'b1;
        powerdown_req = 1'b0;
        array_restore = 1'b0;
        req = '0;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        check("array_mode", 16'(array_mode), 16'h0001);
        repeat (4)
        begin
            seed = lfsr(seed);
            xfer(1'b0, seed[17:0], 16'h0000);
            check("read", q, seed[15:0]);
        end
        $display("test reads done");
        a = seed[17:0];
        d = seed[31:16] | 16'h0100;
        xfer(1'b1, a, 16'h0040);
        xfer(1'b1, a, d);
        xfer(1'b0, a, 16'h0000);
        check("status", q, 16'h0080);
        array_restore = 1'b1;
        @(negedge clk);
        array_restore = 1'b0;
        check("array_mode", 16'(array_mode), 16'h0000);
        xfer(1'b1, a, 16'h00FF);
        xfer(1'b0, a, 16'h0000);
        check("program", q, d);
        check("array_mode", 16'(array_mode), 16'h0001);
        seed = lfsr(seed);
        xfer(1'b1, seed[17:0], d);
        xfer(1'b1, seed[17:0], 16'h00FF);
        xfer(1'b0, seed[17:0], 16'h0000);
        check("single_step", q, seed[15:0]);
        $display("test program done");
        for (int k = 0; k < 2; k++)
        begin
            xfer(1'b1, a, 16'h0040);
            powerdown_req = (k == 0);
            sys_reset_n = (k == 0);
            repeat (8) @(negedge clk);
            sm_setup = 1'b0;
            sm_rd = 1'b1;
            check("reset_pin", 16'(pins.powerdown_reset_n), 16'h0000);
            check("ready", 16'(req_ready), 16'h0000);
            powerdown_req = 1'b0;
            sys_reset_n = 1'b1;
            xfer(1'b0, a, 16'h0000);
            check("wake_read", q, d);
            xfer(1'b1, a, 16'h1234);
            xfer(1'b1, a, 16'h00FF);
            xfer(1'b0, a, 16'h0000);
            check("aborted", q, d);
            $display("test reset path %0d done", k);
        end
        end_sim;
    end
    initial
    begin
        #80000;
        mismatches++;
        end_sim;
    end
endmodule
